// ==== hapm_pkg.sv ====
package hapm_pkg;

    // Host bus type selection, as strapped at reset
    localparam int BUS_SEL_W = 4;
    typedef enum logic [BUS_SEL_W-1:0] {
        HAPM_BUS_GENERIC   = 4'h0,
        HAPM_BUS_STROBE16  = 4'h1,
        HAPM_BUS_CONV32    = 4'h2,
        HAPM_BUS_SYSISA    = 4'h3,
        HAPM_BUS_CARD_A    = 4'h4,
        HAPM_BUS_CARD_B    = 4'h5,
        HAPM_BUS_MSB0      = 4'h6,
        HAPM_BUS_PCCARD    = 4'h7
    } hapm_bus_type;

    // Pin group widths and positions
    localparam int LOW_GRP_W  = 12;
    localparam int MID_GRP_W  = 4;
    localparam int ADDR_W     = 32;
    localparam int POS_LOW_LO = 1;
    localparam int POS_MID_LO = 13;
    localparam int POS_P17    = 17;
    localparam int POS_P18    = 18;
    localparam int POS_P19    = 19;
    localparam int POS_P20    = 20;
    localparam int POS_TOP    = 31;

    // Host bit number sitting in bit position b, most-significant-first
    function automatic int unsigned hapm_msb0_pos(input int unsigned b);
        return POS_TOP - b;
    endfunction

endpackage

// ==== hapm_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module hapm_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

// ==== hapm_mapper.sv ====
// Contract
// - Strobe16 mode: lowest pin is lower data strobe; card mode B bit 31; else address bit 0.
// - Card mode B: lowest pin carries host address bit 31.
// - Msb0 mode: pins 12..1 are bits 19..30; else bits 12..1.
// - Msb0: pins 16..13 are bits 15..18; card modes unused; else 16..13.
// - Card modes: pin 17 is low IO write; msb0 bit 14; else 17.
// - Card modes: pin 18 is low IO read; msb0 bit 13; else 18.
// - Card modes: pin 19 is low register access; msb0 12; else 19.
// - Card modes: pin 20 is latch enable; msb0 bit 11; else 20.
// - Card mode B takes latched address in its own bit numbering.
// - Outside card modes, space select high means display buffer, low means registers.
`timescale 1ns/1ps
`default_nettype none
module hapm_mapper
    import hapm_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rstn_i,
    input  wire logic [BUS_SEL_W-1:0] bus_sel_i,
    input  wire logic                 addr_pin_lowest,
    input  wire logic [LOW_GRP_W-1:0] addr_pins_low_group,
    input  wire logic [MID_GRP_W-1:0] addr_pins_mid_group,
    input  wire logic                 addr_pin_17,
    input  wire logic                 addr_pin_18,
    input  wire logic                 addr_pin_19,
    input  wire logic                 addr_pin_20,
    input  wire logic                 space_sel_i,
    output logic [ADDR_W-1:0]         host_addr_o,
    output logic                      lower_strobe_n_o,
    output logic                      card_io_wr_n_o,
    output logic                      card_io_rd_n_o,
    output logic                      card_reg_n_o,
    output logic                      addr_latch_en_o,
    output logic                      disp_buf_sel_o,
    output logic                      reg_space_sel_o,
    output logic                      mode_valid_o,
    output hapm_bus_type              bus_mode_o
);

    localparam int PIN_W = 1 + LOW_GRP_W + MID_GRP_W + 4;
    // Edges the synchroniser needs to refill after reset clears it
    localparam int SYNC_LAT = 2;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic [BUS_SEL_W-1:0] sel_s;
    logic             sp_s;
    logic             cap_done_q;
    logic [1:0]       cap_cnt_q;
    hapm_bus_type     mode_q;
    logic [ADDR_W-1:0] addr_d;
    logic [ADDR_W-1:0] latched_q;
    logic             ale_q;
    logic             card_mode;
    logic             msb0_mode;

    // Pins arrive from the host bus clock, so resync all of them
    assign pins_raw = {addr_pin_20, addr_pin_19, addr_pin_18, addr_pin_17,
                       addr_pins_mid_group, addr_pins_low_group,
                       addr_pin_lowest};

    hapm_sync2 #(.W(PIN_W + BUS_SEL_W + 1)) u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    ({space_sel_i, bus_sel_i, pins_raw}),
        .sync_o     ({sp_s, sel_s, pins_s})
    );

    // Capture the strap once after release; later changes are ignored.
    // Reset clears the synchroniser, so wait until the strap has refilled
    // it; capturing earlier would always latch the cleared value.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cap_done_q <= 1'b0;
            cap_cnt_q  <= 2'h0;
            mode_q     <= HAPM_BUS_GENERIC;
        end else if (!cap_done_q) begin
            if (cap_cnt_q == 2'(SYNC_LAT)) begin
                cap_done_q <= 1'b1;
                mode_q     <= hapm_bus_type'(sel_s);
            end else begin
                cap_cnt_q  <= cap_cnt_q + 2'h1;
            end
        end
    end

    assign card_mode = (mode_q == HAPM_BUS_CARD_A) ||
                       (mode_q == HAPM_BUS_CARD_B);
    assign msb0_mode = (mode_q == HAPM_BUS_MSB0);

    // Address bit assembly per bus type; unused bits stay zero
    always_comb begin
        addr_d = '0;
        if (msb0_mode) begin
            for (int i = 0; i < LOW_GRP_W; i++) begin
                addr_d[hapm_msb0_pos(POS_LOW_LO + i)] =
                    pins_s[POS_LOW_LO + i];
            end
            for (int i = 0; i < MID_GRP_W; i++) begin
                addr_d[hapm_msb0_pos(POS_MID_LO + i)] =
                    pins_s[POS_MID_LO + i];
            end
            addr_d[hapm_msb0_pos(POS_P17)] = pins_s[POS_P17];
            addr_d[hapm_msb0_pos(POS_P18)] = pins_s[POS_P18];
            addr_d[hapm_msb0_pos(POS_P19)] = pins_s[POS_P19];
            addr_d[hapm_msb0_pos(POS_P20)] = pins_s[POS_P20];
            addr_d[0] = pins_s[0];
        end else if (card_mode) begin
            // Mid group is tied high on card buses and carries nothing
            addr_d[POS_LOW_LO +: LOW_GRP_W] =
                pins_s[POS_LOW_LO +: LOW_GRP_W];
            if (mode_q == HAPM_BUS_CARD_B) begin
                addr_d[POS_TOP] = pins_s[0];
            end else begin
                addr_d[0] = pins_s[0];
            end
        end else begin
            addr_d[POS_LOW_LO +: LOW_GRP_W] =
                pins_s[POS_LOW_LO +: LOW_GRP_W];
            addr_d[POS_MID_LO +: MID_GRP_W] =
                pins_s[POS_MID_LO +: MID_GRP_W];
            addr_d[POS_P17] = pins_s[POS_P17];
            addr_d[POS_P18] = pins_s[POS_P18];
            addr_d[POS_P19] = pins_s[POS_P19];
            // Pin 20 relies on the ISA host having latched it already
            addr_d[POS_P20] = pins_s[POS_P20];
            if (mode_q != HAPM_BUS_STROBE16) begin
                addr_d[0] = pins_s[0];
            end
        end
    end

    // Card buses multiplex address; load it while latch enable is high, hold it while low
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            latched_q <= '0;
            ale_q     <= 1'b0;
        end else begin
            ale_q <= card_mode & pins_s[POS_P20];
            if (!card_mode || pins_s[POS_P20]) begin
                latched_q <= addr_d;
            end
        end
    end

    // Registered command and select outputs, idle values outside modes
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            lower_strobe_n_o <= 1'b1;
            card_io_wr_n_o   <= 1'b1;
            card_io_rd_n_o   <= 1'b1;
            card_reg_n_o     <= 1'b1;
            disp_buf_sel_o   <= 1'b0;
            reg_space_sel_o  <= 1'b0;
        end else begin
            lower_strobe_n_o <= (mode_q == HAPM_BUS_STROBE16) ?
                                pins_s[0] : 1'b1;
            card_io_wr_n_o   <= card_mode ? pins_s[POS_P17] : 1'b1;
            card_io_rd_n_o   <= card_mode ? pins_s[POS_P18] : 1'b1;
            card_reg_n_o     <= card_mode ? pins_s[POS_P19] : 1'b1;
            disp_buf_sel_o   <= cap_done_q & ~card_mode & sp_s;
            reg_space_sel_o  <= cap_done_q & ~card_mode & ~sp_s;
        end
    end

    assign host_addr_o     = latched_q;
    assign addr_latch_en_o = ale_q;
    assign mode_valid_o    = cap_done_q;
    assign bus_mode_o      = mode_q;

endmodule
`default_nettype wire

// ==== hapm_mapper_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module hapm_mapper_asserts
    import hapm_pkg::*;
(
    input wire logic         core_clk_i,
    input wire logic         rstn_i,
    input wire logic         addr_pin_lowest,
    input wire logic [11:0]  addr_pins_low_group,
    input wire logic [3:0]   addr_pins_mid_group,
    input wire logic         addr_pin_17,
    input wire logic         addr_pin_18,
    input wire logic         addr_pin_19,
    input wire logic         addr_pin_20,
    input wire logic         space_sel_i,
    input wire logic [31:0]  host_addr_o,
    input wire logic         lower_strobe_n_o,
    input wire logic         card_io_wr_n_o,
    input wire logic         card_io_rd_n_o,
    input wire logic         card_reg_n_o,
    input wire logic         addr_latch_en_o,
    input wire logic         disp_buf_sel_o,
    input wire logic         reg_space_sel_o,
    input wire logic         mode_valid_o,
    input wire hapm_bus_type bus_mode_o
);
    logic [2:0] vq;
    wire        ok = mode_valid_o & vq[2];
    wire        st = ok && bus_mode_o == HAPM_BUS_STROBE16;
    wire        gn = ok && bus_mode_o == HAPM_BUS_GENERIC;
    wire        ms = ok && bus_mode_o == HAPM_BUS_MSB0;
    wire        cb = ok && bus_mode_o == HAPM_BUS_CARD_B;
    wire        cd = cb || ok && bus_mode_o == HAPM_BUS_CARD_A;
    // Pin history is trusted only three edges past capture (sync pipeline)
    always_ff @(posedge core_clk_i) begin
        vq <= rstn_i ? {vq[1:0], mode_valid_o} : 3'h0;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_strobe_pin: assert property (st |-> !host_addr_o[0] &&
        lower_strobe_n_o == $past(addr_pin_lowest, 3)) else $error("strobe");
    a_plain_low: assert property (gn |-> host_addr_o[12:0] ==
        $past({addr_pins_low_group, addr_pin_lowest}, 3)) else $error("low");
    a_cardb_top: assert property (cb && $past(addr_pin_20, 3) |->
        host_addr_o[31] == $past(addr_pin_lowest, 3)) else $error("top");
    a_msb0_low: assert property (ms |-> host_addr_o[30] ==
        $past(addr_pins_low_group[0], 3) && host_addr_o[18] ==
        $past(addr_pins_mid_group[0], 3)) else $error("msb0 low");
    a_msb0_top: assert property (ms |-> host_addr_o[14:11] ==
        $past({addr_pin_17, addr_pin_18, addr_pin_19, addr_pin_20}, 3))
        else $error("msb0 top");
    a_card_cmds: assert property (cd |-> {card_io_wr_n_o,
        card_io_rd_n_o, card_reg_n_o} == $past({addr_pin_17, addr_pin_18,
        addr_pin_19}, 3)) else $error("card cmd");
    a_card_ale: assert property (cd |-> addr_latch_en_o ==
        $past(addr_pin_20, 3)) else $error("ale");
    a_space_dec: assert property (gn |-> reg_space_sel_o !=
        disp_buf_sel_o && disp_buf_sel_o == $past(space_sel_i, 3))
        else $error("space");
    a_mode_held: assert property (ok |-> $stable(bus_mode_o))
        else $error("mode moved");
    c_strobe_low: cover property (st && !lower_strobe_n_o);
    c_card_ale: cover property (cd && addr_latch_en_o);
    c_msb0_hit: cover property (ms && host_addr_o[30]);
endmodule
bind hapm_mapper hapm_mapper_asserts chk_u (.*);
`default_nettype wire

// ==== hapm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hapm_host_model (
    input  wire logic        core_clk_i,
    input  wire logic [21:0] req_i,
    output logic      [21:0] pins_o
);
    // Host registers every line, so the upper address bit arrives latched
    always_ff @(posedge core_clk_i) begin
        pins_o <= req_i;
    end
endmodule
`default_nettype wire

// ==== hapm_mapper_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    fails++; $display("wrong value %s exp %h got %h", n, e, s); end end
module hapm_mapper_tb_top
    import hapm_pkg::*;
();
    logic         core_clk_i = 1'b0;
    logic         rstn_i     = 1'b0;
    logic [3:0]   bus_sel_i  = 4'h0;
    logic [21:0]  req        = 22'h0;
    logic [21:0]  pins;
    logic [31:0]  addr;
    logic [6:0]   ctl;
    logic         mvld;
    hapm_bus_type mode;
    int           fails = 0, check_count = 0, cyc = 0;
    // Rows: mode, space select, pins, address, control outputs
    logic [64:0]  tbl [9] = '{{4'h0, 22'h35A003, 32'h0015A003, 7'h7A},
        {4'h1, 22'h35A003, 32'h0015A002, 7'h7A},
        {4'h1, 22'h35A002, 32'h0015A002, 7'h3A},
        {4'h2, 22'h15A003, 32'h0015A003, 7'h79},
        {4'h3, 22'h15A003, 32'h0015A003, 7'h79},
        {4'h4, 22'h35A003, 32'h00000003, 7'h54},
        {4'h5, 22'h35A003, 32'h80000002, 7'h54},
        {4'h6, 22'h15A003, 32'h4005A801, 7'h79},
        {4'h7, 22'h35A003, 32'h0015A003, 7'h7A}};
    hapm_mapper dut_u (.core_clk_i, .rstn_i, .bus_sel_i,
        .addr_pin_lowest(pins[0]), .addr_pins_low_group(pins[12:1]),
        .addr_pins_mid_group(pins[16:13]), .addr_pin_17(pins[17]),
        .addr_pin_18(pins[18]), .addr_pin_19(pins[19]),
        .addr_pin_20(pins[20]), .space_sel_i(pins[21]), .host_addr_o(addr),
        .lower_strobe_n_o(ctl[6]), .card_io_wr_n_o(ctl[5]),
        .card_io_rd_n_o(ctl[4]), .card_reg_n_o(ctl[3]),
        .addr_latch_en_o(ctl[2]), .disp_buf_sel_o(ctl[1]),
        .reg_space_sel_o(ctl[0]), .mode_valid_o(mvld), .bus_mode_o(mode));
    hapm_host_model host_u (.core_clk_i, .req_i(req), .pins_o(pins));
    // Clock, and a hang guard well past the expected run length
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report();
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Strap must stay steady three edges after release, since reset clears the sync
    task automatic start(input logic [3:0] m);
        @(posedge core_clk_i);
        rstn_i    <= 1'b0;
        bus_sel_i <= m;
        repeat (4) @(posedge core_clk_i);
        rstn_i    <= 1'b1;
    endtask
    // Host model adds one edge to the three-edge pin latency
    task automatic drive(input logic [21:0] r);
        @(posedge core_clk_i);
        req <= r;
        repeat (6) @(posedge core_clk_i);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK("rst addr", 32'h0, addr)
        `CHK("rst ctl", 7'h78, ctl)
        `CHK("rst valid", 1'b0, mvld)
        foreach (tbl[i]) begin
            start(tbl[i][64:61]);
            drive(tbl[i][60:39]);
            `CHK("mode", tbl[i][64:61], mode)
            `CHK("valid", 1'b1, mvld)
            `CHK("addr", tbl[i][38:7], addr)
            `CHK("ctl", tbl[i][6:0], ctl)
        end
        // A late strap change is ignored until the next reset
        @(posedge core_clk_i);
        bus_sel_i <= 4'h4;
        drive(22'h35A003);
        `CHK("held mode", 4'h7, mode)
        `CHK("held ctl", 7'h7A, ctl)
        // Card address holds while latch enable is low, reloads when high
        start(4'h4);
        drive(22'h35A003);
        drive(22'h200FF0);
        `CHK("latch hold", 32'h3, addr)
        `CHK("cmd low", 7'h40, ctl)
        drive(22'h300FF0);
        `CHK("latch load", 32'hFF0, addr)
        `CHK("ale high", 7'h44, ctl)
        final_report();
    end
endmodule
`default_nettype wire
